// File: common/irq_ctl_params.svh
// Constants of the interrupt control register block
//
// =============================================================
// Notes on behaviour
// - Arrival of maskable interrupt 4-15 or nonmaskable sets its pending flag.
// - Pending flags bits 31-16, 3-2 and 0 read zero, writes ignored.
// - Pending flags read-only; maskable flag changes only by arrival, set or clear.
// - Set register bit n (15-4) at 1 sets flag n; zeros change nothing.
// - Set register never touches nonmaskable or reset flag; bits 31-16, 3-0 ignored.
// - A set register write shows in a pending flags read two cycles later.
// - Same bit written to set and clear in one cycle: set wins.
// - Taking a maskable interrupt loads its return address into the maskable pointer.
// - Taking the nonmaskable interrupt loads its return address into its pointer.
// - Both return pointers are writable; interrupt processing may overwrite them.
// - Table base bits 31-10 load a default at reset, then software may move it.
// - Reset forces table base back to its default.
// - Bits 9-5 of table pointer give highest pending and enabled flag number.
// - Highest pending number reads 0 when nothing is pending and enabled.
// - Global enable ignored; each source, maskable or nonmaskable, needs its own enable.
// - Bits 4-0 of table pointer read zero, 32-byte vector alignment.
// - Table pointer access is refused in user mode.
// - A read-only register shows the fetch packet address in the first execute stage.
// - In emulation mode debug mask bits 31, 30, 15-4 mark high-priority sources.
// - Debug mask bits 31-2 change only while its write select bit 1 is 0.
// - Arrival beats a simultaneous clear of the same flag.
// - An interrupt counts as enabled only when its individual enable bit is 1.
`ifndef IRQ_CTL_PARAMS_SVH
`define IRQ_CTL_PARAMS_SVH

// =============================================================
// Register selects of the control register move port
`define SEL_PENDING 4'h0
`define SEL_SET 4'h1
`define SEL_MRET 4'h2
`define SEL_TABLE 4'h3
`define SEL_NRET 4'h4
`define SEL_E1PC 4'h5
`define SEL_DEBUG 4'h6

// =============================================================
// Field positions and reset values
`define NMI_BIT 1
`define TBASE_LSB 10
`define HPN_LSB 5
`define DBG_NMI_BIT 31
`define DBG_EXC_BIT 30
`define WRITE_SELECT_BIT 1
`define TBASE_RESET 22'h000000
`define DEBUG_RESET 32'h00000000

`endif

// File: common/irq_ctl_pkg.sv
// Types of the interrupt control register block
`default_nettype none
package irq_ctl_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] sel;
		logic [31:0] wdata;
	} cr_req_type;

	typedef struct packed {
		logic [15:4] flags;
		logic nonmaskable_flag;
		logic [15:4] set_p;
		logic [15:4] clr_p;
		logic [31:0] mret;
		logic [31:0] nret;
		logic [21:0] tbase;
		logic [1:0] dbg_hi;
		logic [15:4] dbg_int;
		logic write_select;
		logic dbg0;
		logic [31:0] rdata;
		logic rvalid;
		logic fault;
		logic hipri;
		logic [31:0] vec;
	} state_type;

endpackage
`default_nettype wire

// File: verilog/irq_prio_pick.sv
// Priority pick of the highest pending and enabled interrupt number
`default_nettype none
module irq_prio_pick (
	input wire logic [15:4] pend,
	input wire logic nonmaskable_flag,
	input wire logic [15:4] ie,
	input wire logic nonmaskable_enable,
	output logic [4:0] num
);
	logic [15:4] live;

	// Walk from lowest priority upward so the highest priority overwrites
	always_comb begin
		live = pend & ie;
		num = 5'h00;
		for (int i = 15; i >= 4; i--) begin
			if (live[i]) begin
				num = 5'(i);
			end
		end
		if (nonmaskable_flag && nonmaskable_enable) begin
			num = 5'h01;
		end
	end

endmodule
`default_nettype wire

// File: verilog/irq_ctl_regs.sv
// Interrupt control registers: flags, set, pointers, table pointer, debug mask
`include "irq_ctl_params.svh"
`default_nettype none
module irq_ctl_regs (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire irq_ctl_pkg::cr_req_type CR_REQ,
	input wire logic USER_MODE,
	input wire logic [15:4] MASK_LINES,
	input wire logic NMI_LINE,
	input wire logic [15:4] CLEAR_BITS,
	input wire logic [15:4] IE_BITS,
	input wire logic NMI_ENABLE,
	input wire logic TAKE_MASKABLE,
	input wire logic TAKE_NMI,
	input wire logic [31:0] RETURN_ADDR,
	input wire logic [31:0] E1_ADDR,
	input wire logic EMU_MODE,
	input wire logic EXTERNAL_EXCEPTION_LINE,
	output logic [31:0] CR_RDATA,
	output logic CR_RVALID,
	output logic CR_FAULT,
	output logic HIGH_PRI,
	output logic [31:0] VECTOR_ADDR
);

	// =============================================================
	// State
	irq_ctl_pkg::state_type st_r;
	irq_ctl_pkg::state_type st_nxt;
	logic [4:0] hpn;
	logic wr_set;
	logic wr_mret;
	logic wr_table;
	logic wr_nret;
	logic wr_debug;
	logic table_hit;
	logic refused;
	logic [31:0] table_word;
	logic [31:0] pend_word;
	logic [31:0] debug_word;

	// =============================================================
	// Priority pick
	irq_prio_pick u_pick (
		.pend(st_r.flags),
		.nonmaskable_flag(st_r.nonmaskable_flag),
		.ie(IE_BITS),
		.nonmaskable_enable(NMI_ENABLE),
		.num(hpn)
	);

	// =============================================================
	// Decode
	assign table_hit = (CR_REQ.wr || CR_REQ.rd) && (CR_REQ.sel == `SEL_TABLE);
	assign refused = table_hit && USER_MODE;
	assign wr_set = CR_REQ.wr && (CR_REQ.sel == `SEL_SET);
	assign wr_mret = CR_REQ.wr && (CR_REQ.sel == `SEL_MRET);
	assign wr_table = CR_REQ.wr && (CR_REQ.sel == `SEL_TABLE) && !USER_MODE;
	assign wr_nret = CR_REQ.wr && (CR_REQ.sel == `SEL_NRET);
	assign wr_debug = CR_REQ.wr && (CR_REQ.sel == `SEL_DEBUG);

	// Low five bits stay zero so every vector lands on a 32-byte packet
	assign table_word = {st_r.tbase, hpn, 5'h00};
	// Reserved and reset flag positions are constant zero
	assign pend_word = {16'h0000, st_r.flags, 2'b00, st_r.nonmaskable_flag, 1'b0};
	assign debug_word = {st_r.dbg_hi, 14'h0000, st_r.dbg_int, 2'b00, st_r.write_select, st_r.dbg0};

	// =============================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Set and clear both wait one stage, so they meet the flags
		// together and a read two cycles later sees the result
		st_nxt.set_p = wr_set ? CR_REQ.wdata[15:4] : 12'h000;
		st_nxt.clr_p = CLEAR_BITS;
		// Clear first, then set and arrival on top: both beat the clear
		st_nxt.flags = (st_r.flags & ~(st_r.clr_p & ~st_r.set_p))
			| st_r.set_p
			| MASK_LINES;
		// Taking the nonmaskable interrupt consumes its flag
		if (TAKE_NMI) begin
			st_nxt.nonmaskable_flag = 1'b0;
		end
		if (NMI_LINE) begin
			st_nxt.nonmaskable_flag = 1'b1;
		end

		// Pointers: software write first, interrupt processing overrides
		if (wr_mret) begin
			st_nxt.mret = CR_REQ.wdata;
		end
		if (TAKE_MASKABLE) begin
			st_nxt.mret = RETURN_ADDR;
		end
		if (wr_nret) begin
			st_nxt.nret = CR_REQ.wdata;
		end
		if (TAKE_NMI) begin
			st_nxt.nret = RETURN_ADDR;
		end

		if (wr_table) begin
			st_nxt.tbase = CR_REQ.wdata[31:`TBASE_LSB];
		end

		// Debug mask: the write select guard uses the stored bit
		if (wr_debug) begin
			st_nxt.write_select = CR_REQ.wdata[`WRITE_SELECT_BIT];
			st_nxt.dbg0 = CR_REQ.wdata[0];
			if (!st_r.write_select) begin
				st_nxt.dbg_hi = CR_REQ.wdata[31:30];
				st_nxt.dbg_int = CR_REQ.wdata[15:4];
			end
		end

		// Read answer, registered one cycle after the request
		st_nxt.rvalid = CR_REQ.rd;
		st_nxt.fault = refused;
		st_nxt.rdata = 32'h00000000;
		if (CR_REQ.rd && !refused) begin
			case (CR_REQ.sel)
				`SEL_PENDING: st_nxt.rdata = pend_word;
				`SEL_MRET: st_nxt.rdata = st_r.mret;
				`SEL_TABLE: st_nxt.rdata = table_word;
				`SEL_NRET: st_nxt.rdata = st_r.nret;
				`SEL_E1PC: st_nxt.rdata = E1_ADDR;
				`SEL_DEBUG: st_nxt.rdata = debug_word;
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end

		// High-priority request in real-time emulation mode
		st_nxt.hipri = EMU_MODE && ((st_r.dbg_hi[1] && st_r.nonmaskable_flag)
			|| (st_r.dbg_hi[0] && EXTERNAL_EXCEPTION_LINE)
			|| (|(st_r.dbg_int & st_r.flags)));
		st_nxt.vec = table_word;
	end

	// =============================================================
	// Registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_r <= '0;
			st_r.tbase <= `TBASE_RESET;
			st_r.dbg_hi <= 2'(`DEBUG_RESET >> 30);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign CR_RDATA = st_r.rdata;
	assign CR_RVALID = st_r.rvalid;
	assign CR_FAULT = st_r.fault;
	assign HIGH_PRI = st_r.hipri;
	assign VECTOR_ADDR = st_r.vec;

	// =============================================================
	// Checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	sequence set_write;
		wr_set && (CR_REQ.wdata[15:4] != 12'h000);
	endsequence

	sequence set_and_clear;
		wr_set && ((CR_REQ.wdata[15:4] & CLEAR_BITS) != 12'h000);
	endsequence

	sequence nmi_read;
		CR_REQ.rd && (CR_REQ.sel == `SEL_PENDING);
	endsequence

	chk_set_delay: assert property (set_write |-> ##2
		((st_r.flags & $past(CR_REQ.wdata[15:4], 2)) == $past(CR_REQ.wdata[15:4], 2)))
		else $error("set write not visible after two cycles");

	chk_set_early: assert property ((wr_set && (MASK_LINES == 12'h000))
		|=> ((st_r.flags & ~$past(st_r.flags)) == 12'h000) || ($past(MASK_LINES) != 12'h000)
		|| ($past(st_r.set_p) != 12'h000))
		else $error("set write visible one cycle early");

	chk_set_wins: assert property (set_and_clear |=> ##1
		((st_r.flags & $past(CR_REQ.wdata[15:4] & CLEAR_BITS, 2))
		== $past(CR_REQ.wdata[15:4] & CLEAR_BITS, 2)))
		else $error("clear beat a set of the same bit");

	chk_arrival_wins: assert property ((MASK_LINES != 12'h000)
		|=> ((st_r.flags & $past(MASK_LINES)) == $past(MASK_LINES)))
		else $error("arriving interrupt lost");

	chk_nmi_arrival: assert property (NMI_LINE |=> st_r.nonmaskable_flag)
		else $error("nonmaskable flag not set");

	chk_flag_zeros: assert property ((nmi_read and !refused) |=>
		(CR_RDATA[31:16] == 16'h0000) && (CR_RDATA[3:2] == 2'b00) && !CR_RDATA[0])
		else $error("reserved flag bits not zero");

	chk_mret_load: assert property (TAKE_MASKABLE |=> (st_r.mret == $past(RETURN_ADDR)))
		else $error("maskable return pointer not loaded");

	chk_nret_load: assert property (TAKE_NMI |=> (st_r.nret == $past(RETURN_ADDR)))
		else $error("nonmaskable return pointer not loaded");

	chk_user_refuse: assert property (table_hit && USER_MODE
		|=> CR_FAULT && (CR_RDATA == 32'h00000000) && $stable(st_r.tbase))
		else $error("table pointer access not refused in user mode");

	chk_write_select_block: assert property ((wr_debug && st_r.write_select)
		|=> $stable(st_r.dbg_int) && $stable(st_r.dbg_hi))
		else $error("debug mask changed while write select set");

	chk_hpn_zero: assert property ((((st_r.flags & IE_BITS) == 12'h000)
		&& !(st_r.nonmaskable_flag && NMI_ENABLE)) |-> (hpn == 5'h00))
		else $error("highest pending number not zero");

	chk_table_low: assert property (CR_REQ.rd && (CR_REQ.sel == `SEL_TABLE) && !USER_MODE
		|=> (CR_RDATA[4:0] == 5'h00) && (CR_RDATA[9:5] == $past(hpn)))
		else $error("table pointer low field wrong");

	chk_reset_base: assert property (disable iff (1'b0) RST |=>
		(st_r.tbase == `TBASE_RESET))
		else $error("table base not restored by reset");

endmodule
`default_nettype wire

// File: bench/pipe_model.sv
// Pipeline model: first execute stage packet address and interrupt take pulses
`default_nettype none
module pipe_model (
	input wire logic clk,
	input wire logic go_m,
	input wire logic go_n,
	output logic take_m,
	output logic take_n,
	output logic [31:0] ret_addr,
	output logic [31:0] e1_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		e1_addr = 32'h00008000;
		take_m = 1'h0;
		take_n = 1'h0;
	end
	// Packet in E1 is the first one left unexecuted by a take
	assign ret_addr = e1_addr;
	// =====
	// Late update keeps outputs clear of the bench's own drive instant
	// Each take overwrites whatever software wrote to the pointer
	always @(posedge clk) begin
		e1_addr <= #3 e1_addr + 32'h00000020;
		take_m <= #3 go_m;
		take_n <= #3 go_n;
	end
endmodule
`default_nettype wire

// File: bench/dsp_interrupt_control_regs_test.sv
// Self-checking bench of the interrupt control register block
`include "irq_ctl_params.svh"
`default_nettype none
module dsp_interrupt_control_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic SYS_CLK = 1'h0, RST = 1'h1, USER_MODE = 1'h0, NMI_LINE = 1'h0, NMI_ENABLE = 1'h0;
	logic EMU_MODE = 1'h0, EXTERNAL_EXCEPTION_LINE = 1'h0, go_m = 1'h0, go_n = 1'h0;
	logic TAKE_MASKABLE, TAKE_NMI, CR_RVALID, CR_FAULT, HIGH_PRI;
	logic [15:4] MASK_LINES = '0, CLEAR_BITS = '0, IE_BITS = '0;
	logic [31:0] RETURN_ADDR, E1_ADDR, CR_RDATA, VECTOR_ADDR, w, exp_v;
	irq_ctl_pkg::cr_req_type CR_REQ = '0;
	int num_errors = 0, checks = 0, seed = 32'hC2ED;
	always #5 SYS_CLK = ~SYS_CLK;
	irq_ctl_regs uut (.SYS_CLK, .RST, .CR_REQ, .USER_MODE, .MASK_LINES, .NMI_LINE,
		.CLEAR_BITS, .IE_BITS, .NMI_ENABLE, .TAKE_MASKABLE, .TAKE_NMI, .RETURN_ADDR,
		.E1_ADDR, .EMU_MODE, .EXTERNAL_EXCEPTION_LINE, .CR_RDATA, .CR_RVALID, .CR_FAULT, .HIGH_PRI,
		.VECTOR_ADDR);
	pipe_model cpu (.clk(SYS_CLK), .go_m, .go_n, .take_m(TAKE_MASKABLE),
		.take_n(TAKE_NMI), .ret_addr(RETURN_ADDR), .e1_addr(E1_ADDR));
	// =====
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	// Request stays up until the next one replaces it, so no double drive per step
	task automatic cr(input logic wr, input logic rd, input logic [3:0] sel, input logic [31:0] d);
		CR_REQ = '{wr, rd, sel, d};
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic rdc(input logic [3:0] sel, input logic [31:0] want);
		cr(1'h0, 1'h1, sel, 32'h00000000);
		check(CR_RDATA, want);
		check({31'h00000000, CR_RVALID}, 32'h00000001);
	endtask
	task automatic take(input logic nmi, input logic [3:0] sel);
		go_m = ~nmi;
		go_n = nmi;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		go_m = 1'h0;
		go_n = 1'h0;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		exp_v = RETURN_ADDR;
		rdc(sel, exp_v);
		w = $random(seed);
		cr(1'h1, 1'h0, sel, w);
		rdc(sel, w);
	endtask
	function automatic logic [4:0] hpn(input logic [15:4] f, input logic nf,
		input logic [15:4] ie, input logic ne);
		hpn = 5'h00;
		for (int n = 15; n >= 4; n--) if (f[n] & ie[n]) hpn = 5'(n);
		if (nf & ne) hpn = 5'h01;
	endfunction
	task automatic note(input string s);
		$display("test %s finished", s);
	endtask
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// =====
	// Watchdog
	initial begin
		repeat (3000) @(posedge SYS_CLK);
		num_errors++;
		test_done();
	end
	// =====
	// Main sequence
	initial begin
		repeat (3) @(posedge SYS_CLK);
		#1;
		RST = 1'h0;
		rdc(`SEL_PENDING, 32'h00000000);
		rdc(`SEL_TABLE, {`TBASE_RESET, 10'h000});
		rdc(4'h9, 32'h00000000);
		note("reset");
		w = $random(seed);
		cr(1'h1, 1'h0, `SEL_SET, w);
		rdc(`SEL_PENDING, 32'h00000000);
		rdc(`SEL_PENDING, {16'h0000, w[15:4], 4'h0});
		rdc(`SEL_SET, 32'h00000000);
		cr(1'h1, 1'h0, `SEL_PENDING, 32'hFFFFFFFF);
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		rdc(`SEL_PENDING, {16'h0000, w[15:4], 4'h0});
		NMI_LINE = 1'h1;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		NMI_LINE = 1'h0;
		rdc(`SEL_PENDING, {16'h0000, w[15:4], 4'h2});
		for (int i = 0; i < 8; i++) begin
			IE_BITS = (i == 0) ? 12'h000 : 12'($random(seed));
			NMI_ENABLE = i[0];
			cr(1'h0, 1'h0, 4'h0, 32'h00000000);
			check(VECTOR_ADDR, {`TBASE_RESET, hpn(w[15:4], 1'h1, IE_BITS, NMI_ENABLE), 5'h00});
		end
		note("set and priority");
		CLEAR_BITS = 12'hFFF;
		cr(1'h1, 1'h0, `SEL_SET, 32'h0000FFF0);
		CLEAR_BITS = 12'h000;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		rdc(`SEL_PENDING, 32'h0000FFF2);
		// The clear lands one cycle after its write, so the arrival is timed to meet it
		CLEAR_BITS = 12'hFFF;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		CLEAR_BITS = 12'h000;
		MASK_LINES = 12'h0A5;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		MASK_LINES = 12'h000;
		rdc(`SEL_PENDING, 32'h00000A52);
		CLEAR_BITS = 12'hFFF;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		CLEAR_BITS = 12'h000;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		rdc(`SEL_PENDING, 32'h00000002);
		note("clear races");
		take(1'h1, `SEL_NRET);
		take(1'h0, `SEL_MRET);
		cr(1'h0, 1'h1, `SEL_E1PC, 32'h00000000);
		check(CR_RDATA, E1_ADDR);
		note("return pointers");
		USER_MODE = 1'h1;
		cr(1'h0, 1'h1, `SEL_TABLE, 32'h00000000);
		check({CR_RDATA[30:0], CR_FAULT}, 32'h00000001);
		cr(1'h1, 1'h0, `SEL_TABLE, 32'hFFFFFFFF);
		check({31'h00000000, CR_FAULT}, 32'h00000001);
		USER_MODE = 1'h0;
		rdc(`SEL_TABLE, {`TBASE_RESET, 10'h000});
		w = $random(seed);
		cr(1'h1, 1'h0, `SEL_TABLE, w);
		rdc(`SEL_TABLE, {w[31:10], 10'h000});
		RST = 1'h1;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		RST = 1'h0;
		rdc(`SEL_TABLE, {`TBASE_RESET, 10'h000});
		note("table pointer");
		cr(1'h1, 1'h0, `SEL_DEBUG, 32'hFFFFFFF0);
		rdc(`SEL_DEBUG, 32'hC000FFF0);
		EMU_MODE = 1'h1;
		EXTERNAL_EXCEPTION_LINE = 1'h1;
		cr(1'h0, 1'h0, 4'h0, 32'h00000000);
		check({31'h00000000, HIGH_PRI}, 32'h00000001);
		EMU_MODE = 1'h0;
		cr(1'h1, 1'h0, `SEL_DEBUG, 32'hFFFFFFFF);
		check({31'h00000000, HIGH_PRI}, 32'h00000000);
		rdc(`SEL_DEBUG, 32'hC000FFF3);
		cr(1'h1, 1'h0, `SEL_DEBUG, 32'h00000000);
		rdc(`SEL_DEBUG, 32'hC000FFF0);
		note("debug mask");
		test_done();
	end
endmodule
`default_nettype wire
